//--- verilog/status_outputs_regs.svh
`ifndef STATUS_OUTPUTS_REGS_SVH
`define STATUS_OUTPUTS_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define OFS_ROT_LEVEL 8'h00
`define OFS_VCMP_WIDTH 8'h04
`define OFS_POSITIONING_COMPLETED_OUT_WIDTH 8'h08
`define OFS_TIMING_SEL 8'h0c
`define OFS_CONFIG 8'h10
`define OFS_ALLOC 8'h14
`define OFS_FLAGS 8'h18
`define OFS_IRQ_STATUS 8'h1c
`define OFS_IRQ_MASK 8'h20

// ----------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------
`define ROT_LEVEL_MIN 14'h0001
`define ROT_LEVEL_MAX 14'h2710
`define ROT_LEVEL_RST 14'h0014
`define VCMP_WIDTH_MAX 7'h64
`define VCMP_WIDTH_RST 7'h0a
`define POSITIONING_COMPLETED_OUT_WIDTH_MAX 31'h40000000
`define POSITIONING_COMPLETED_OUT_WIDTH_RST 31'h00000007

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_ABS_ENC_BIT 0
`define CFG_RESTART_BIT 1
`define FLAG_WARN 0
`define FLAG_ROT 1
`define FLAG_READY 2
`define FLAG_VCMP 3
`define FLAG_POSITIONING_COMPLETED_OUT 4
`define NUM_FLAGS 5
`define NUM_PINS 3
`define ALLOC_BITS 2

`endif

//--- verilog/status_outputs_pkg.sv
package status_outputs_pkg;

    // control loop the drive is running
    typedef enum logic [1:0] {
        MODE_SPEED,
        MODE_POSITION,
        MODE_TORQUE
    } ctrl_mode_t;

    // qualifier for positioning-completed
    typedef enum logic [1:0] {
        TIMING_ERROR_ONLY,
        TIMING_FILTERED_ZERO,
        TIMING_INPUT_ZERO
    } timing_sel_t;

endpackage

//--- verilog/status_pin_mux.sv
`timescale 1ns/1ns
`include "status_outputs_regs.svh"

// routes each status flag to the pin its allocation field names
module status_pin_mux (
    input wire logic clk, // control clock
    input wire logic rst_n, // synchronous reset
    input wire logic [`NUM_FLAGS-1:0] flags, // asserted flags
    input wire logic [`NUM_FLAGS*`ALLOC_BITS-1:0] alloc, // pin per flag, 0 = none
    output logic [`NUM_PINS-1:0] pins_q // 1 = contact closed
);

    // ----------------------------------------------------------------
    // pin combine
    // ----------------------------------------------------------------
    logic [`NUM_PINS-1:0] pins_d;

    // unallocated flags reach no pin; shared pins act as or
    always_comb begin
        pins_d = '0;
        for (int f = 0; f < `NUM_FLAGS; f++) begin
            for (int p = 0; p < `NUM_PINS; p++) begin
                if (alloc[f*`ALLOC_BITS +: `ALLOC_BITS] == `ALLOC_BITS'(p + 1) && flags[f]) begin
                    pins_d[p] = 1'b1;
                end
            end
        end
    end

    // open contacts while in reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins_d;
        end
    end

endmodule

//--- verilog/servo_status_outputs.sv
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ns
`include "status_outputs_regs.svh"

module servo_status_outputs
    import status_outputs_pkg::*;
(
    input wire logic clk, // control clock, 125 mhz
    input wire logic rst_n, // synchronous reset
    input wire logic [7:0] address, // byte address
    input wire logic read, // read request
    input wire logic write, // write request
    input wire logic [31:0] writedata, // write data
    input wire logic [3:0] byteenable, // byte lanes
    output logic [31:0] readdata, // read data
    output logic waitrequest, // stall
    input wire logic main_power_on, // main circuit supply on
    input wire logic hardwired_base_block, // base block active
    input wire logic alarm_active, // any alarm present
    input wire logic warning_active, // any warning present
    input wire logic encoder_power_on_command, // one-cycle command pulse
    input wire logic abs_data_sent, // absolute data sent to host
    input wire logic servo_on_command, // one-cycle command pulse
    input wire status_outputs_pkg::ctrl_mode_t ctrl_mode, // running loop
    input wire logic signed [15:0] motor_speed, // rpm, signed
    input wire logic signed [15:0] reference_speed, // rpm, signed
    input wire logic signed [31:0] position_error, // reference units
    input wire logic filtered_ref_zero, // filtered reference is zero
    input wire logic ref_input_zero, // reference input is zero
    output logic servo_on_accept_q, // pulse, servo-on taken
    output logic servo_on_refused_q, // pulse, servo-on refused
    output logic [`NUM_PINS-1:0] status_pins_q, // contacts, 1 = closed
    output logic irq_q // level interrupt
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // magnitude of a signed value
    function automatic logic [32:0] magnitude(input logic signed [32:0] v);
        magnitude = v[32] ? 33'(-v) : 33'(v);
    endfunction

    // merge write data into a word under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [13:0] rot_level_q;
    logic [6:0] vcmp_width_q;
    logic [30:0] positioning_completed_out_width_q;
    logic [1:0] timing_pend_q;
    timing_sel_t timing_q;
    logic abs_enc_q;
    logic [`NUM_FLAGS*`ALLOC_BITS-1:0] alloc_q;
    logic [`NUM_FLAGS-1:0] flags_q;
    logic [`NUM_FLAGS-1:0] flags_d;
    logic [`NUM_FLAGS-1:0] irq_status_q;
    logic [`NUM_FLAGS-1:0] irq_mask_q;
    logic encoder_on_q;
    logic [31:0] readdata_d;
    logic wr_take;
    logic rd_take;
    logic [31:0] wr_word;
    logic [32:0] speed_mag;
    logic [32:0] speed_diff_mag;
    logic [32:0] pos_err_mag;
    logic positioning_completed_out_qual;

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------

    // write lands on the edge waitrequest is low; read data latched on the edge it drops
    assign wr_take = write && !waitrequest;
    assign rd_take = read && waitrequest;

    // one wait state per access: drop waitrequest for one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------

    // word as software would see it after the write
    always_comb begin
        wr_word = merge(readdata_d, writedata, byteenable);
    end

    // detection level, clamped into its range
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rot_level_q <= `ROT_LEVEL_RST;
        end else if (wr_take && address == `OFS_ROT_LEVEL) begin
            if (wr_word[31:14] != '0 || wr_word[13:0] > `ROT_LEVEL_MAX) begin
                rot_level_q <= `ROT_LEVEL_MAX;
            end else if (wr_word[13:0] < `ROT_LEVEL_MIN) begin
                rot_level_q <= `ROT_LEVEL_MIN;
            end else begin
                rot_level_q <= wr_word[13:0];
            end
        end
    end

    // coincidence width, clamped to 100
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vcmp_width_q <= `VCMP_WIDTH_RST;
        end else if (wr_take && address == `OFS_VCMP_WIDTH) begin
            if (wr_word[31:7] != '0 || wr_word[6:0] > `VCMP_WIDTH_MAX) begin
                vcmp_width_q <= `VCMP_WIDTH_MAX;
            end else begin
                vcmp_width_q <= wr_word[6:0];
            end
        end
    end

    // completed width, clamped to its maximum
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            positioning_completed_out_width_q <= `POSITIONING_COMPLETED_OUT_WIDTH_RST;
        end else if (wr_take && address == `OFS_POSITIONING_COMPLETED_OUT_WIDTH) begin
            if (wr_word[31] || wr_word[30:0] > `POSITIONING_COMPLETED_OUT_WIDTH_MAX) begin
                positioning_completed_out_width_q <= `POSITIONING_COMPLETED_OUT_WIDTH_MAX;
            end else begin
                positioning_completed_out_width_q <= wr_word[30:0];
            end
        end
    end

    // timing code is stored, then applied only at restart
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timing_pend_q <= 2'h0;
            timing_q <= TIMING_ERROR_ONLY;
        end else begin
            if (wr_take && address == `OFS_TIMING_SEL) begin
                timing_pend_q <= wr_word[1:0];
            end
            if (wr_take && address == `OFS_CONFIG && wr_word[`CFG_RESTART_BIT]) begin
                unique case (timing_pend_q)
                    2'h1: timing_q <= TIMING_FILTERED_ZERO;
                    2'h2: timing_q <= TIMING_INPUT_ZERO;
                    default: timing_q <= TIMING_ERROR_ONLY;
                endcase
            end
        end
    end

    // encoder type and pin allocation
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            abs_enc_q <= 1'b0;
            alloc_q <= '0;
        end else if (wr_take) begin
            if (address == `OFS_CONFIG) begin
                abs_enc_q <= wr_word[`CFG_ABS_ENC_BIT];
            end
            if (address == `OFS_ALLOC) begin
                alloc_q <= wr_word[`NUM_FLAGS*`ALLOC_BITS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // encoder power-on latch
    // ----------------------------------------------------------------

    // command counts only once absolute data has gone out
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            encoder_on_q <= 1'b0;
        end else if (encoder_power_on_command && abs_data_sent) begin
            encoder_on_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // comparisons
    // ----------------------------------------------------------------

    // magnitudes of speed, speed difference and position error
    always_comb begin
        speed_mag = magnitude(33'(motor_speed));
        speed_diff_mag = magnitude(33'(reference_speed) - 33'(motor_speed));
        pos_err_mag = magnitude(33'(position_error));
    end

    // extra qualifier chosen by the timing code
    always_comb begin
        unique case (timing_q)
            TIMING_ERROR_ONLY: positioning_completed_out_qual = 1'b1;
            TIMING_FILTERED_ZERO: positioning_completed_out_qual = filtered_ref_zero;
            TIMING_INPUT_ZERO: positioning_completed_out_qual = ref_input_zero;
            default: positioning_completed_out_qual = 1'b1;
        endcase
    end

    // flag conditions
    always_comb begin
        flags_d = '0;
        flags_d[`FLAG_WARN] = warning_active;
        flags_d[`FLAG_ROT] = speed_mag >= 33'(rot_level_q);
        flags_d[`FLAG_READY] = main_power_on && !hardwired_base_block && !alarm_active
                               && (!abs_enc_q || encoder_on_q);
        flags_d[`FLAG_VCMP] = (ctrl_mode == MODE_SPEED)
                              && (speed_diff_mag < 33'(vcmp_width_q));
        flags_d[`FLAG_POSITIONING_COMPLETED_OUT] = (ctrl_mode == MODE_POSITION)
                              && (pos_err_mag < 33'(positioning_completed_out_width_q)) && positioning_completed_out_qual;
    end

    // registered flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ----------------------------------------------------------------
    // servo-on acceptance
    // ----------------------------------------------------------------

    // only a ready drive takes the servo-on command
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            servo_on_accept_q <= 1'b0;
            servo_on_refused_q <= 1'b0;
        end else begin
            servo_on_accept_q <= servo_on_command && flags_q[`FLAG_READY];
            servo_on_refused_q <= servo_on_command && !flags_q[`FLAG_READY];
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------

    // rising flags set sticky bits; a set beats a write-one clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_status_q <= '0;
        end else begin
            for (int i = 0; i < `NUM_FLAGS; i++) begin
                if (flags_d[i] && !flags_q[i]) begin
                    irq_status_q[i] <= 1'b1;
                end else if (wr_take && address == `OFS_IRQ_STATUS && byteenable[0] && writedata[i]) begin
                    irq_status_q[i] <= 1'b0;
                end
            end
        end
    end

    // mask register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_mask_q <= '0;
        end else if (wr_take && address == `OFS_IRQ_MASK) begin
            irq_mask_q <= wr_word[`NUM_FLAGS-1:0];
        end
    end

    // interrupt level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------

    // unmapped addresses read zero
    always_comb begin
        readdata_d = '0;
        unique case (address)
            `OFS_ROT_LEVEL: readdata_d[13:0] = rot_level_q;
            `OFS_VCMP_WIDTH: readdata_d[6:0] = vcmp_width_q;
            `OFS_POSITIONING_COMPLETED_OUT_WIDTH: readdata_d[30:0] = positioning_completed_out_width_q;
            `OFS_TIMING_SEL: readdata_d[1:0] = timing_pend_q;
            `OFS_CONFIG: readdata_d[`CFG_ABS_ENC_BIT] = abs_enc_q;
            `OFS_ALLOC: readdata_d[`NUM_FLAGS*`ALLOC_BITS-1:0] = alloc_q;
            `OFS_FLAGS: readdata_d = {26'h0, encoder_on_q, flags_q};
            `OFS_IRQ_STATUS: readdata_d[`NUM_FLAGS-1:0] = irq_status_q;
            `OFS_IRQ_MASK: readdata_d[`NUM_FLAGS-1:0] = irq_mask_q;
            default: readdata_d = '0;
        endcase
    end

    // read data captured as waitrequest drops, held until next read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata <= '0;
        end else if (rd_take) begin
            readdata <= readdata_d;
        end
    end

    // ----------------------------------------------------------------
    // pin routing
    // ----------------------------------------------------------------
    status_pin_mux u_pin_mux (
        .clk(clk),
        .rst_n(rst_n),
        .flags(flags_q),
        .alloc(alloc_q),
        .pins_q(status_pins_q)
    );

endmodule

//--- test/host_ctrl_model.sv
`timescale 1ns/1ns

// ----------------------------------------
// host side: asks for servo-on, logs answer
// ----------------------------------------
module host_ctrl_model (
    input wire logic clk, // control clock
    input wire logic rst_n, // sync reset
    input wire logic go, // bench wants servo-on
    input wire logic accept, // drive took it
    input wire logic refuse, // drive refused it
    output logic cmd_q, // one-cycle servo-on pulse
    output logic [1:0] res_q // 01 taken, 10 refused
);
    // one pulse per request, then latch the answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_q <= 1'b0;
            res_q <= 2'h0;
        end else begin
            cmd_q <= go && !cmd_q;
            if (go)
                res_q <= 2'h0;
            else if (accept)
                res_q <= 2'h1;
            else if (refuse)
                res_q <= 2'h2;
        end
    end
endmodule

//--- test/servo_status_outputs_checker.sv
`timescale 1ns/1ns
`include "status_outputs_regs.svh"

// ----------------------------------------
// port-level checks
// ----------------------------------------
module servo_status_checker (
    input wire logic clk, // control clock
    input wire logic rst_n, // sync reset
    input wire logic read, // read request
    input wire logic write, // write request
    input wire logic [31:0] readdata, // read data
    input wire logic waitrequest, // stall
    input wire logic main_power_on, // supply on
    input wire logic hardwired_base_block, // base block
    input wire logic alarm_active, // alarm
    input wire logic servo_on_command, // servo-on pulse
    input wire logic servo_on_accept_q, // taken pulse
    input wire logic servo_on_refused_q, // refused pulse
    input wire logic [`NUM_PINS-1:0] status_pins_q, // contacts
    input wire logic irq_q // interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // bus handshake
    wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered in one cycle");
    wait_one_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    wait_cause_a: assert property (!waitrequest |-> $past(read || write))
        else $error("answer without request");
    rdata_hold_a: assert property (!$stable(readdata) |-> $past(read))
        else $error("readdata moved without read");
    rst_out_a: assert property ($rose(rst_n) |-> waitrequest && !irq_q && status_pins_q == '0 && readdata == '0)
        else $error("outputs not at reset values");
    // servo-on answers
    sv_answer_a: assert property (servo_on_command |=> servo_on_accept_q != servo_on_refused_q)
        else $error("servo-on not answered once");
    sv_cause_a: assert property (servo_on_accept_q || servo_on_refused_q |-> $past(servo_on_command))
        else $error("servo-on answer without command");
    sv_ready_a: assert property (servo_on_accept_q |->
        $past(main_power_on, 2) && !$past(alarm_active, 2) && !$past(hardwired_base_block, 2))
        else $error("servo-on taken while not ready");

    // main scenarios
    accept_c: cover property (servo_on_accept_q);
    refuse_c: cover property (servo_on_refused_q);
    irq_c: cover property ($rose(irq_q));
endmodule

bind servo_status_outputs servo_status_checker chk_i (.clk, .rst_n, .read, .write, .readdata, .waitrequest,
    .main_power_on, .hardwired_base_block, .alarm_active, .servo_on_command, .servo_on_accept_q,
    .servo_on_refused_q, .status_pins_q, .irq_q);

//--- test/testbench.sv
`timescale 1ns/1ns
`include "status_outputs_regs.svh"

module testbench;
    import status_outputs_pkg::*;
    typedef struct {ctrl_mode_t m; logic signed [15:0] s; logic signed [15:0] r;
        logic signed [31:0] e; logic w; logic [31:0] f;} row_t;
    logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, go = 1'b0;
    logic [7:0] address = 8'h0;
    logic [31:0] writedata = 32'h0, readdata;
    logic [3:0] byteenable = 4'hf;
    logic waitrequest, servo_on_accept_q, servo_on_refused_q, irq_q, servo_on_command;
    logic [2:0] status_pins_q;
    logic [1:0] host_res;
    logic main_power_on = 1'b1, hardwired_base_block = 1'b0, alarm_active = 1'b0, warning_active = 1'b0;
    logic encoder_power_on_command = 1'b0, abs_data_sent = 1'b0, filtered_ref_zero = 1'b0, ref_input_zero = 1'b0;
    ctrl_mode_t ctrl_mode = MODE_SPEED;
    logic signed [15:0] motor_speed = 16'sh0, reference_speed = 16'sh0;
    logic signed [31:0] position_error = 32'sh0;
    int err_count = 0, n_checks = 0;
    // mode, speed, reference, error, warning, expected flags
    row_t rows [6] = '{'{MODE_SPEED, 16'sh14, 16'sh19, 32'sh0, 1'b0, 32'he},
        '{MODE_SPEED, -16'sh13, -16'sh9, 32'sh0, 1'b0, 32'h4},
        '{MODE_POSITION, -16'sh14, 16'sh64, -32'sh6, 1'b1, 32'h17},
        '{MODE_POSITION, 16'sh0, 16'sh0, 32'sh7, 1'b0, 32'h4},
        '{MODE_TORQUE, 16'sh0, 16'sh0, 32'sh0, 1'b0, 32'h4},
        '{MODE_SPEED, -16'sh9, 16'sh0, 32'sh0, 1'b0, 32'hc}};

    // ----------------------------------------
    // clock, design and host
    // ----------------------------------------
    always #4 clk = ~clk;

    servo_status_outputs dut (.clk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .main_power_on, .hardwired_base_block, .alarm_active, .warning_active,
        .encoder_power_on_command, .abs_data_sent, .servo_on_command, .ctrl_mode, .motor_speed,
        .reference_speed, .position_error, .filtered_ref_zero, .ref_input_zero, .servo_on_accept_q,
        .servo_on_refused_q, .status_pins_q, .irq_q);

    host_ctrl_model host (.clk, .rst_n, .go, .accept(servo_on_accept_q), .refuse(servo_on_refused_q),
        .cmd_q(servo_on_command), .res_q(host_res));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        write <= wr_en;
        read <= !wr_en;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20)
            err_count++;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    // drive the measured values, then let flags settle
    task automatic setin(input ctrl_mode_t m, input logic signed [15:0] s, input logic signed [15:0] r,
        input logic signed [31:0] e, input logic w, input logic [1:0] z);
        @(posedge clk);
        ctrl_mode <= m;
        motor_speed <= s;
        reference_speed <= r;
        position_error <= e;
        warning_active <= w;
        {ref_input_zero, filtered_ref_zero} <= z;
        repeat (4) @(posedge clk);
    endtask

    task automatic servo_on(input logic [1:0] e);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
        chk({30'h0, host_res}, {30'h0, e});
    endtask

    task automatic enc_on(input logic sent);
        @(posedge clk);
        abs_data_sent <= sent;
        encoder_power_on_command <= 1'b1;
        @(posedge clk);
        encoder_power_on_command <= 1'b0;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(`OFS_ROT_LEVEL, 32'h14);
        rd(`OFS_VCMP_WIDTH, 32'ha);
        rd(`OFS_POSITIONING_COMPLETED_OUT_WIDTH, 32'h7);
        rd(8'h30, 32'h0);
        foreach (rows[i]) begin
            setin(rows[i].m, rows[i].s, rows[i].r, rows[i].e, rows[i].w, 2'h0);
            rd(`OFS_FLAGS, rows[i].f);
            chk({29'h0, status_pins_q}, 32'h0);
        end
        // detection level clamps and acts at once
        wr(`OFS_ROT_LEVEL, 32'h0);
        rd(`OFS_ROT_LEVEL, 32'h1);
        wr(`OFS_ROT_LEVEL, 32'h2711);
        rd(`OFS_ROT_LEVEL, 32'h2710);
        wr(`OFS_ROT_LEVEL, 32'h64);
        setin(MODE_TORQUE, -16'sh64, 16'sh0, 32'sh0, 1'b0, 2'h0);
        rd(`OFS_FLAGS, 32'h6);
        setin(MODE_TORQUE, 16'sh63, 16'sh0, 32'sh0, 1'b0, 2'h0);
        rd(`OFS_FLAGS, 32'h4);
        // coincidence width bounds
        wr(`OFS_VCMP_WIDTH, 32'hc8);
        rd(`OFS_VCMP_WIDTH, 32'h64);
        wr(`OFS_VCMP_WIDTH, 32'h0);
        setin(MODE_SPEED, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h0);
        rd(`OFS_FLAGS, 32'h4);
        // completed timing codes wait for restart
        wr(`OFS_TIMING_SEL, 32'h1);
        setin(MODE_POSITION, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h0);
        rd(`OFS_FLAGS, 32'h14);
        wr(`OFS_CONFIG, 32'h2);
        setin(MODE_POSITION, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h0);
        rd(`OFS_FLAGS, 32'h4);
        setin(MODE_POSITION, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h1);
        rd(`OFS_FLAGS, 32'h14);
        wr(`OFS_TIMING_SEL, 32'h2);
        wr(`OFS_CONFIG, 32'h2);
        setin(MODE_POSITION, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h1);
        rd(`OFS_FLAGS, 32'h4);
        setin(MODE_POSITION, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h2);
        rd(`OFS_FLAGS, 32'h14);
        // interrupt, mask, clear and pin allocation
        setin(MODE_TORQUE, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h0);
        wr(`OFS_IRQ_STATUS, 32'h1f);
        rd(`OFS_IRQ_STATUS, 32'h0);
        wr(`OFS_ALLOC, 32'h8);
        setin(MODE_TORQUE, 16'sh64, 16'sh0, 32'sh0, 1'b0, 2'h0);
        rd(`OFS_IRQ_STATUS, 32'h2);
        // a zero write with the status lane disabled leaves the bit set
        byteenable <= 4'he;
        wr(`OFS_IRQ_STATUS, 32'h0);
        byteenable <= 4'hf;
        rd(`OFS_IRQ_STATUS, 32'h2);
        chk({31'h0, irq_q}, 32'h0);
        chk({29'h0, status_pins_q}, 32'h2);
        wr(`OFS_IRQ_MASK, 32'h2);
        repeat (3) @(posedge clk);
        chk({31'h0, irq_q}, 32'h1);
        setin(MODE_TORQUE, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h0);
        chk({29'h0, status_pins_q}, 32'h0);
        wr(`OFS_IRQ_STATUS, 32'h2);
        repeat (3) @(posedge clk);
        chk({31'h0, irq_q}, 32'h0);
        // absolute encoder ready sequence and refusals
        wr(`OFS_CONFIG, 32'h1);
        enc_on(1'b0);
        setin(MODE_TORQUE, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h0);
        rd(`OFS_FLAGS, 32'h0);
        servo_on(2'h2);
        enc_on(1'b1);
        setin(MODE_TORQUE, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h0);
        rd(`OFS_FLAGS, 32'h24);
        servo_on(2'h1);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            alarm_active <= (i == 0);
            hardwired_base_block <= (i == 1);
            main_power_on <= (i != 2);
            setin(MODE_TORQUE, 16'sh0, 16'sh0, 32'sh0, 1'b0, 2'h0);
            rd(`OFS_FLAGS, 32'h20);
            servo_on(2'h2);
        end
        end_of_test();
    end

    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        end_of_test();
    end
endmodule
